//--- rtl/host_pin_defs.vh
// constants for the x86-style host pin interface
`ifndef HOST_PIN_DEFS_VH
`define HOST_PIN_DEFS_VH
// register indices on reg_addr (7 bits)
`define ADDR_MODE_A 7'h00
`define ADDR_STATE_A 7'h01
`define ADDR_CMD_A 7'h02
`define ADDR_DATA_A 7'h03
`define ADDR_MODE_B 7'h08
`define ADDR_STATE_B 7'h09
`define ADDR_CMD_B 7'h0a
`define ADDR_DATA_B 7'h0b
`define ADDR_INT_MASK 7'h05
`define ADDR_INT_PEND 7'h04
`define ADDR_OUT_PORT 7'h0e
`define ADDR_PORT_CFG 7'h0d
`define ADDR_PORT_DIR_A 7'h10
`define ADDR_PORT_DIR_B 7'h11
`define ADDR_PORT_IN_A 7'h12
`define ADDR_PORT_IN_B 7'h13
`define ADDR_COS 7'h14
`define ADDR_BAUD_DIV 7'h15
`define ADDR_OUT_PORT_B 7'h16
`define LOW_SPACE_TOP 7'h10
// reset values
`define RST_MODE 8'h13
`define RST_BYTE 8'h00
// command register bits
`define CMD_RX_EN 0
`define CMD_TX_EN 2
`define CMD_LOOP 4
// state register bits
`define ST_RX_RDY 0
`define ST_TX_RDY 2
`define ST_TX_EMPTY 3
// interrupt pending bit positions
`define INT_TX_A 0
`define INT_RX_A 1
`define INT_COS_A 2
`define INT_TX_B 4
`define INT_RX_B 5
`define INT_COS_B 6
`define INT_TIMER 3
`define INT_OVR 7
// port config encodings per pin, two bits
`define PCFG_GPIO 2'h0
`define PCFG_RX_READY_FLAG 2'h1
`define PCFG_TX_READY_FLAG 2'h2
`define PCFG_TMRDY 2'h3
// timing
`define CLK_HZ 125000000
`define BAUD_DEFAULT 9600
`define ACK_EDGES 2
`endif

//--- rtl/host_pin_if.v
// x86-style host bus port, interrupt, serial and port-pin logic of a dual uart
`include "host_pin_defs.vh"
module host_pin_if #(
	parameter CLK_HZ = `CLK_HZ,
	parameter BAUD = `BAUD_DEFAULT
) (
	// clock and resets
	input wire core_clk,
	input wire arst_n,
	input wire reset_in,
	input wire bus_format,
	// host bus
	input wire select_n,
	input wire write_strobe_n,
	input wire read_strobe_n,
	input wire [6:0] reg_addr,
	input wire [7:0] host_data_in,
	output reg [7:0] host_data_out,
	output reg host_data_oe,
	output reg xfer_ack_n,
	output reg xfer_ack_oe,
	// interrupt, open drain
	output reg irq_out_n,
	output reg irq_oe,
	// serial lines
	input wire rxd_a,
	input wire rxd_b,
	output reg txd_a,
	output reg txd_b,
	// port pins
	input wire [7:0] port_a_in,
	output reg [7:0] port_a_out,
	output reg [7:0] port_a_oe,
	input wire [7:0] port_b_in,
	output reg [7:0] port_b_out,
	output reg [7:0] port_b_oe
);
	localparam integer DIV_FULL = CLK_HZ / BAUD;
	localparam [15:0] BAUD_DIV = DIV_FULL[15:0];
	// bus states, one hot
	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_WAIT = 4'h2;
	localparam [3:0] S_ACC = 4'h4;
	localparam [3:0] S_DONE = 4'h8;

	function low_space;
		input [6:0] a;
		begin
			low_space = (a < `LOW_SPACE_TOP);
		end
	endfunction

	// --------------------------------------------------------
	// synchronisers
	// --------------------------------------------------------
	reg [2:0] sel_s1, sel_s2;
	reg [1:0] rx_s1, rx_s2;
	reg [15:0] pin_s1, pin_s2, pin_prev;
	reg rst_s1, rst_s2, fmt_s1, fmt_s2, fmt_r;
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sel_s1 <= 3'h7;
			sel_s2 <= 3'h7;
			rx_s1 <= 2'h3;
			rx_s2 <= 2'h3;
			pin_s1 <= 16'h0000;
			pin_s2 <= 16'h0000;
			pin_prev <= 16'h0000;
			rst_s1 <= 1'b1;
			rst_s2 <= 1'b1;
			fmt_s1 <= 1'b1;
			fmt_s2 <= 1'b1;
			fmt_r <= 1'b1;
		end
		else
		begin
			sel_s1 <= {select_n, write_strobe_n, read_strobe_n};
			sel_s2 <= sel_s1;
			rx_s1 <= {rxd_b, rxd_a};
			rx_s2 <= rx_s1;
			pin_s1 <= {port_b_in, port_a_in};
			pin_s2 <= pin_s1;
			pin_prev <= pin_s2;
			rst_s1 <= reset_in;
			rst_s2 <= rst_s1;
			fmt_s1 <= bus_format;
			fmt_s2 <= fmt_s1;
			fmt_r <= fmt_s2;
		end
	end
	// only the x86 format is built; the 68k format leaves the port idle
	wire x86 = fmt_r;
	wire soft_rst = rst_s2 & x86;
	wire sel = ~sel_s2[2] & x86;
	wire wr = ~sel_s2[1];
	wire rd = ~sel_s2[0];

	// --------------------------------------------------------
	// registers
	// --------------------------------------------------------
	reg [7:0] mode_a_r [0:1];
	reg [7:0] mode_b_r [0:1];
	reg mptr_a_r, mptr_b_r;
	reg [7:0] cmd_a_r, cmd_b_r, imask_r, ipend_r, out_port_r, out_port_b_r, port_cfg_r;
	reg [7:0] dir_a_r, dir_b_r, cos_r, rx_data_a_r, rx_data_b_r;
	reg [15:0] baud_div_r;
	reg [3:0] bus_st_r;
	reg [6:0] addr_r;
	reg [7:0] wdata_r;
	reg rx_rdy_a_r, rx_rdy_b_r, tx_busy_a_r, tx_busy_b_r, ovr_a_r, ovr_b_r;
	reg [7:0] tx_hold_a_r, tx_hold_b_r;
	reg tx_load_a_r, tx_load_b_r;
	reg rd_data_a, rd_data_b;

	// address capture and write commit
	wire commit_wr = (bus_st_r == S_ACC) & ~wr & ~rd;
	reg [7:0] rdata_nxt;
	always @*
	begin
		rdata_nxt = 8'h00;
		case (addr_r)
			`ADDR_MODE_A: rdata_nxt = mode_a_r[mptr_a_r];
			`ADDR_MODE_B: rdata_nxt = mode_b_r[mptr_b_r];
			`ADDR_STATE_A: rdata_nxt = {ovr_a_r, 4'h0, ~tx_busy_a_r, ~tx_load_a_r, rx_rdy_a_r};
			`ADDR_STATE_B: rdata_nxt = {ovr_b_r, 4'h0, ~tx_busy_b_r, ~tx_load_b_r, rx_rdy_b_r};
			`ADDR_DATA_A: rdata_nxt = rx_data_a_r;
			`ADDR_DATA_B: rdata_nxt = rx_data_b_r;
			`ADDR_INT_MASK: rdata_nxt = imask_r;
			`ADDR_INT_PEND: rdata_nxt = ipend_r;
			`ADDR_OUT_PORT: rdata_nxt = out_port_r;
			`ADDR_PORT_CFG: rdata_nxt = port_cfg_r;
			`ADDR_PORT_DIR_A: rdata_nxt = dir_a_r;
			`ADDR_PORT_DIR_B: rdata_nxt = dir_b_r;
			`ADDR_PORT_IN_A: rdata_nxt = pin_s2[7:0];
			`ADDR_PORT_IN_B: rdata_nxt = pin_s2[15:8];
			`ADDR_COS: rdata_nxt = cos_r;
			`ADDR_BAUD_DIV: rdata_nxt = baud_div_r[7:0];
			`ADDR_OUT_PORT_B: rdata_nxt = out_port_b_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// --------------------------------------------------------
	// bus sequencer
	// --------------------------------------------------------
	reg rd_active_r;
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			bus_st_r <= S_IDLE;
			addr_r <= 7'h00;
			wdata_r <= 8'h00;
			rd_active_r <= 1'b0;
			host_data_out <= 8'h00;
			host_data_oe <= 1'b0;
			xfer_ack_n <= 1'b1;
			xfer_ack_oe <= 1'b0;
			rd_data_a <= 1'b0;
			rd_data_b <= 1'b0;
		end
		else
		begin
			rd_data_a <= 1'b0;
			rd_data_b <= 1'b0;
			host_data_oe <= sel & rd_active_r;
			xfer_ack_oe <= sel;
			case (bus_st_r)
				S_IDLE:
				begin
					xfer_ack_n <= 1'b1;
					rd_active_r <= 1'b0;
					if (sel)
						bus_st_r <= S_WAIT;
				end
				S_WAIT:
				begin
					// second edge after select: access may start
					if (!sel)
						bus_st_r <= S_IDLE;
					else if (wr | rd)
					begin
						addr_r <= reg_addr;
						bus_st_r <= S_ACC;
					end
				end
				S_ACC:
				begin
					addr_r <= reg_addr;
					xfer_ack_n <= 1'b0;
					if (rd)
					begin
						rd_active_r <= 1'b1;
						host_data_out <= rdata_nxt;
					end
					if (wr)
						wdata_r <= host_data_in;
					if (~wr & ~rd)
					begin
						bus_st_r <= S_DONE;
						rd_data_a <= rd_active_r & (addr_r == `ADDR_DATA_A);
						rd_data_b <= rd_active_r & (addr_r == `ADDR_DATA_B);
					end
				end
				S_DONE:
				begin
					rd_active_r <= 1'b0;
					xfer_ack_n <= 1'b1;
					bus_st_r <= sel ? S_WAIT : S_IDLE;
				end
				default: bus_st_r <= S_IDLE;
			endcase
		end
	end
	// write commits on rising strobe: data latched while low
	wire do_wr = commit_wr & ~rd_active_r;

	// --------------------------------------------------------
	// register file
	// --------------------------------------------------------
	wire [7:0] ev_nxt;
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mode_a_r[0] <= `RST_MODE;
			mode_a_r[1] <= `RST_BYTE;
			mode_b_r[0] <= `RST_MODE;
			mode_b_r[1] <= `RST_BYTE;
			mptr_a_r <= 1'b0;
			mptr_b_r <= 1'b0;
			cmd_a_r <= 8'h00;
			cmd_b_r <= 8'h00;
			imask_r <= 8'h00;
			ipend_r <= 8'h00;
			out_port_r <= 8'h00;
			out_port_b_r <= 8'h00;
			port_cfg_r <= 8'h00;
			dir_a_r <= 8'h00;
			dir_b_r <= 8'h00;
			cos_r <= 8'h00;
			baud_div_r <= BAUD_DIV;
			tx_hold_a_r <= 8'h00;
			tx_hold_b_r <= 8'h00;
			tx_load_a_r <= 1'b0;
			tx_load_b_r <= 1'b0;
		end
		else if (soft_rst)
		begin
			mptr_a_r <= 1'b0;
			mptr_b_r <= 1'b0;
			mode_a_r[0] <= `RST_MODE;
			mode_b_r[0] <= `RST_MODE;
			baud_div_r <= BAUD_DIV;
			cmd_a_r <= 8'h00;
			cmd_b_r <= 8'h00;
			imask_r <= 8'h00;
			ipend_r <= 8'h00;
			out_port_r <= 8'h00;
			out_port_b_r <= 8'h00;
			port_cfg_r <= 8'h00;
			dir_a_r <= 8'h00;
			dir_b_r <= 8'h00;
			cos_r <= 8'h00;
			tx_load_a_r <= 1'b0;
			tx_load_b_r <= 1'b0;
		end
		else
		begin
			// set wins over write-one-to-clear
			ipend_r <= (ipend_r & ~((do_wr && addr_r == `ADDR_INT_PEND) ? wdata_r : 8'h00))
				| ev_nxt;
			cos_r <= (cos_r & ~((do_wr && addr_r == `ADDR_COS) ? wdata_r : 8'h00))
				| (pin_s2[7:0] ^ pin_prev[7:0]) | (pin_s2[15:8] ^ pin_prev[15:8]);
			if (tx_busy_a_r)
				tx_load_a_r <= 1'b0;
			if (tx_busy_b_r)
				tx_load_b_r <= 1'b0;
			if (do_wr)
			begin
				case (addr_r)
					`ADDR_MODE_A:
					begin
						mode_a_r[mptr_a_r] <= wdata_r;
						mptr_a_r <= 1'b1;
					end
					`ADDR_MODE_B:
					begin
						mode_b_r[mptr_b_r] <= wdata_r;
						mptr_b_r <= 1'b1;
					end
					`ADDR_CMD_A: cmd_a_r <= wdata_r;
					`ADDR_CMD_B: cmd_b_r <= wdata_r;
					`ADDR_DATA_A:
					begin
						tx_hold_a_r <= wdata_r;
						tx_load_a_r <= cmd_a_r[`CMD_TX_EN];
					end
					`ADDR_DATA_B:
					begin
						tx_hold_b_r <= wdata_r;
						tx_load_b_r <= cmd_b_r[`CMD_TX_EN];
					end
					`ADDR_INT_MASK: imask_r <= wdata_r;
					`ADDR_OUT_PORT: out_port_r <= wdata_r;
					`ADDR_OUT_PORT_B: out_port_b_r <= wdata_r;
					`ADDR_PORT_CFG: port_cfg_r <= wdata_r;
					`ADDR_PORT_DIR_A: dir_a_r <= wdata_r;
					`ADDR_PORT_DIR_B: dir_b_r <= wdata_r;
					`ADDR_BAUD_DIV: baud_div_r <= {8'h00, wdata_r};
					default: ;
				endcase
			end
		end
	end

	// --------------------------------------------------------
	// serial channels
	// --------------------------------------------------------
	reg [15:0] tcnt_a, tcnt_b, rcnt_a, rcnt_b, tmr_r;
	reg [3:0] tbit_a, tbit_b, rbit_a, rbit_b;
	reg [8:0] tsh_a, tsh_b;
	reg [7:0] rsh_a, rsh_b;
	reg rbusy_a, rbusy_b;
	wire tick_tmr = (tmr_r == 16'h0000) & cmd_a_r[`CMD_RX_EN];
	assign ev_nxt = {ovr_a_r | ovr_b_r, cos_r[7:4] != 4'h0, rx_rdy_b_r, ~tx_busy_b_r & ~tx_load_b_r
		& cmd_b_r[`CMD_TX_EN], tick_tmr, cos_r[3:0] != 4'h0, rx_rdy_a_r,
		~tx_busy_a_r & ~tx_load_a_r & cmd_a_r[`CMD_TX_EN]};
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{tcnt_a, tcnt_b, rcnt_a, rcnt_b, tmr_r} <= {5{16'h0000}};
			{tbit_a, tbit_b, rbit_a, rbit_b} <= 16'h0000;
			{tsh_a, tsh_b} <= 18'h00000;
			{rsh_a, rsh_b, rx_data_a_r, rx_data_b_r} <= 32'h00000000;
			{rbusy_a, rbusy_b, tx_busy_a_r, tx_busy_b_r} <= 4'h0;
			{rx_rdy_a_r, rx_rdy_b_r, ovr_a_r, ovr_b_r} <= 4'h0;
			txd_a <= 1'b1;
			txd_b <= 1'b1;
		end
		else if (soft_rst)
		begin
			tmr_r <= 16'h0000;
			{tx_busy_a_r, tx_busy_b_r, rbusy_a, rbusy_b} <= 4'h0;
			{rx_rdy_a_r, rx_rdy_b_r, ovr_a_r, ovr_b_r} <= 4'h0;
			txd_a <= 1'b1;
			txd_b <= 1'b1;
		end
		else
		begin
			tmr_r <= (tmr_r == 16'h0000) ? baud_div_r : tmr_r - 16'h0001;
			// transmitter a
			if (!tx_busy_a_r)
			begin
				txd_a <= 1'b1;
				if (tx_load_a_r && !cmd_a_r[`CMD_LOOP])
				begin
					tsh_a <= {tx_hold_a_r, 1'b0};
					tx_busy_a_r <= 1'b1;
					tbit_a <= 4'h0;
					tcnt_a <= baud_div_r;
				end
			end
			else if (tcnt_a == 16'h0000)
			begin
				txd_a <= (tbit_a == 4'h9) ? 1'b1 : tsh_a[0];
				tsh_a <= {1'b1, tsh_a[8:1]};
				tcnt_a <= baud_div_r;
				tbit_a <= tbit_a + 4'h1;
				if (tbit_a == 4'h9)
					tx_busy_a_r <= 1'b0;
			end
			else
				tcnt_a <= tcnt_a - 16'h0001;
			// transmitter b
			if (!tx_busy_b_r)
			begin
				txd_b <= 1'b1;
				if (tx_load_b_r && !cmd_b_r[`CMD_LOOP])
				begin
					tsh_b <= {tx_hold_b_r, 1'b0};
					tx_busy_b_r <= 1'b1;
					tbit_b <= 4'h0;
					tcnt_b <= baud_div_r;
				end
			end
			else if (tcnt_b == 16'h0000)
			begin
				txd_b <= (tbit_b == 4'h9) ? 1'b1 : tsh_b[0];
				tsh_b <= {1'b1, tsh_b[8:1]};
				tcnt_b <= baud_div_r;
				tbit_b <= tbit_b + 4'h1;
				if (tbit_b == 4'h9)
					tx_busy_b_r <= 1'b0;
			end
			else
				tcnt_b <= tcnt_b - 16'h0001;
			// receiver a: low is space, start bit
			if (rd_data_a)
				rx_rdy_a_r <= 1'b0;
			if (!rbusy_a)
			begin
				if (cmd_a_r[`CMD_RX_EN] && !rx_s2[0])
				begin
					rbusy_a <= 1'b1;
					rbit_a <= 4'h0;
					rcnt_a <= {1'b0, baud_div_r[15:1]};
				end
			end
			else if (rcnt_a == 16'h0000)
			begin
				rcnt_a <= baud_div_r;
				rbit_a <= rbit_a + 4'h1;
				if (rbit_a != 4'h0 && rbit_a != 4'h9)
					rsh_a <= {rx_s2[0], rsh_a[7:1]};
				if (rbit_a == 4'h9)
				begin
					rbusy_a <= 1'b0;
					rx_data_a_r <= rsh_a;
					rx_rdy_a_r <= 1'b1;
					ovr_a_r <= ovr_a_r | (rx_rdy_a_r & ~rd_data_a);
				end
			end
			else
				rcnt_a <= rcnt_a - 16'h0001;
			// receiver b
			if (rd_data_b)
				rx_rdy_b_r <= 1'b0;
			if (!rbusy_b)
			begin
				if (cmd_b_r[`CMD_RX_EN] && !rx_s2[1])
				begin
					rbusy_b <= 1'b1;
					rbit_b <= 4'h0;
					rcnt_b <= {1'b0, baud_div_r[15:1]};
				end
			end
			else if (rcnt_b == 16'h0000)
			begin
				rcnt_b <= baud_div_r;
				rbit_b <= rbit_b + 4'h1;
				if (rbit_b != 4'h0 && rbit_b != 4'h9)
					rsh_b <= {rx_s2[1], rsh_b[7:1]};
				if (rbit_b == 4'h9)
				begin
					rbusy_b <= 1'b0;
					rx_data_b_r <= rsh_b;
					rx_rdy_b_r <= 1'b1;
					ovr_b_r <= ovr_b_r | (rx_rdy_b_r & ~rd_data_b);
				end
			end
			else
				rcnt_b <= rcnt_b - 16'h0001;
		end
	end

	// --------------------------------------------------------
	// port pins and interrupt output
	// --------------------------------------------------------
	// port_cfg_r[1:0] picks the function of pin 0 of port a, port_cfg_r[3:2] of port b, others are plain gpio
	wire [1:0] fn_a = port_cfg_r[1:0];
	wire [1:0] fn_b = port_cfg_r[3:2];
	wire rdy_a = (fn_a == `PCFG_RX_READY_FLAG) ? rx_rdy_a_r : (fn_a == `PCFG_TX_READY_FLAG) ? ~tx_busy_a_r :
		tick_tmr;
	wire rdy_b = (fn_b == `PCFG_RX_READY_FLAG) ? rx_rdy_b_r : (fn_b == `PCFG_TX_READY_FLAG) ? ~tx_busy_b_r :
		tick_tmr;
	wire lo_a = low_space(addr_r);
	always @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			port_a_out <= 8'h00;
			port_a_oe <= 8'h00;
			port_b_out <= 8'h00;
			port_b_oe <= 8'h00;
			irq_out_n <= 1'b0;
			irq_oe <= 1'b0;
		end
		else
		begin
			irq_out_n <= 1'b0;
			irq_oe <= ((ipend_r & imask_r) != 8'h00) & ~soft_rst;
			port_a_out <= out_port_r;
			port_b_out <= out_port_b_r;
			if (soft_rst || (lo_a && bus_st_r == S_ACC))
				port_a_oe <= 8'h00;
			else if (fn_a != `PCFG_GPIO)
			begin
				port_a_out <= {out_port_r[7:1], 1'b0};
				port_a_oe <= {dir_a_r[7:1], ~rdy_a};
			end
			else
				port_a_oe <= dir_a_r;
			if (soft_rst)
				port_b_oe <= 8'h00;
			else if (lo_a && bus_st_r == S_ACC)
				port_b_oe <= 8'hff;
			else if (fn_b != `PCFG_GPIO)
			begin
				port_b_out <= {out_port_b_r[7:1], 1'b0};
				port_b_oe <= {dir_b_r[7:1], ~rdy_b};
			end
			else
				port_b_oe <= dir_b_r;
		end
	end
endmodule // host_pin_if

//--- dv/host_model.sv
// host processor model that drives the x86-style strobe bus
module host_model (
	// clock
	input wire logic core_clk,
	// bus pins
	output logic select_n,
	output logic write_strobe_n,
	output logic read_strobe_n,
	output logic [6:0] reg_addr,
	output logic [7:0] host_data_in,
	input wire logic [7:0] host_data_out,
	input wire logic host_data_oe,
	input wire logic xfer_ack_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic drive_r;
	logic [7:0] wdata_r;
	logic [7:0] last_r;
	int timeouts;
	// no pull on the data lines, so a floating bus shows the inverse of its last level
	assign host_data_in = drive_r ? wdata_r : (host_data_oe ? host_data_out : ~last_r);
	always @(posedge core_clk)
	begin
		last_r <= host_data_in;
	end
	initial
	begin
		select_n = 1'b1;
		write_strobe_n = 1'b1;
		read_strobe_n = 1'b1;
		reg_addr = 7'h00;
		drive_r = 1'b0;
		wdata_r = 8'h00;
		last_r = 8'h00;
		timeouts = 0;
	end
	// ----------------------------------------
	// one access, held until the acknowledge is sampled
	// ----------------------------------------
	task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		@(posedge core_clk);
		select_n <= 1'b0;
		reg_addr <= addr;
		wdata_r <= wd;
		drive_r <= wr;
		write_strobe_n <= !wr;
		read_strobe_n <= wr;
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (!(xfer_ack_n === 1'b0 && (wr || host_data_oe === 1'b1)) && n < 40);
		rd = host_data_out;
		timeouts += (n >= 40);
		write_strobe_n <= 1'b1;
		read_strobe_n <= 1'b1;
		select_n <= 1'b1;
		// data and address stay put past the strobe rise for hold time
		n = 0;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (xfer_ack_n !== 1'b1 && n < 40);
		timeouts += (n >= 40);
		drive_r <= 1'b0;
		repeat (2) @(posedge core_clk);
	endtask
endmodule // host_model

//--- dv/host_pin_sva.sv
// port assertions for the host pin interface
module host_pin_sva (
	// clock and resets
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic reset_in,
	// host bus
	input wire logic select_n,
	input wire logic write_strobe_n,
	input wire logic read_strobe_n,
	input wire logic [6:0] reg_addr,
	input wire logic host_data_oe,
	input wire logic xfer_ack_n,
	// interrupt, serial and port pins
	input wire logic irq_out_n,
	input wire logic txd_a,
	input wire logic txd_b,
	input wire logic [7:0] port_a_oe,
	input wire logic [7:0] port_b_oe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	chk_irq_only_low: assert property (irq_out_n == 1'b0)
		else $error("irq pin driven high");
	chk_data_float: assert property (select_n [*4] |-> !host_data_oe)
		else $error("data bus driven while deselected");
	chk_read_drive: assert property (
		$rose(host_data_oe) |-> !select_n && !$past(read_strobe_n, 2))
		else $error("data bus driven without read strobe");
	chk_ack_after_sel: assert property (
		$fell(xfer_ack_n) |-> !$past(select_n, 1) && !$past(select_n, 2))
		else $error("acknowledge too soon after select");
	chk_ack_sync: assert property (
		$fell(xfer_ack_n) |-> !$past(write_strobe_n, 2) || !$past(read_strobe_n, 2))
		else $error("acknowledge without synchronised strobe");
	chk_ack_release: assert property (
		(write_strobe_n && read_strobe_n) [*5] |-> xfer_ack_n)
		else $error("acknowledge held after strobes");
	chk_tx_mark_reset: assert property (reset_in [*4] |-> txd_a && txd_b)
		else $error("serial output not at mark in reset");
	chk_port_float: assert property (
		(reset_in && select_n) [*4] |-> port_a_oe == 8'h00 && port_b_oe == 8'h00)
		else $error("port pins driven in reset");
	chk_low_space_a: assert property (
		!xfer_ack_n && !$past(xfer_ack_n) && reg_addr < 7'h10 && $stable(reg_addr)
		|-> port_a_oe == 8'h00)
		else $error("port a driven in low space access");
	chk_low_space_b: assert property (
		!xfer_ack_n && !$past(xfer_ack_n) && reg_addr < 7'h10 && $stable(reg_addr)
		|-> port_b_oe == 8'hff)
		else $error("port b not driven in low space access");
endmodule // host_pin_sva
bind host_pin_if host_pin_sva host_pin_sva_i (.core_clk, .arst_n, .reset_in, .select_n,
	.write_strobe_n, .read_strobe_n, .reg_addr, .host_data_oe, .xfer_ack_n, .irq_out_n,
	.txd_a, .txd_b, .port_a_oe, .port_b_oe);

//--- dv/duart_x86_host_pin_interface_test.sv
// self-checking bench for the host pin interface
`include "host_pin_defs.vh"
module duart_x86_host_pin_interface_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CLK_HZ = 125000000;
	// short bit time; the divider counts down through zero, so a bit lasts divider plus one
	localparam int BAUD = 7812500;
	localparam int BIT_CLKS = CLK_HZ / BAUD + 1;
	logic core_clk, arst_n, reset_in, rxd_a;
	logic [7:0] port_a_in, port_b_in, got;
	wire select_n, write_strobe_n, read_strobe_n, host_data_oe, xfer_ack_n, xfer_ack_oe;
	wire irq_out_n, irq_oe, txd_a, txd_b;
	wire [6:0] reg_addr;
	wire [7:0] host_data_in, host_data_out, port_a_out, port_a_oe, port_b_out, port_b_oe;
	int num_errors, checks;
	host_pin_if #(.CLK_HZ(CLK_HZ), .BAUD(BAUD)) host_pin_if_i (.core_clk(core_clk),
		.arst_n(arst_n), .reset_in(reset_in), .bus_format(1'b1), .select_n(select_n),
		.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .reg_addr(reg_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
		.xfer_ack_n(xfer_ack_n), .xfer_ack_oe(xfer_ack_oe), .irq_out_n(irq_out_n),
		.irq_oe(irq_oe), .rxd_a(rxd_a), .rxd_b(1'b1), .txd_a(txd_a), .txd_b(txd_b),
		.port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
		.port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe));
	host_model host_model_i (.core_clk(core_clk), .select_n(select_n),
		.write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n), .reg_addr(reg_addr),
		.host_data_in(host_data_in), .host_data_out(host_data_out),
		.host_data_oe(host_data_oe), .xfer_ack_n(xfer_ack_n));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wd,
		output logic [7:0] rd);
		host_model_i.access(wr, addr, wd, rd);
		if (host_model_i.timeouts != 0)
		begin
			num_errors++;
			give_verdict();
		end
	endtask
	task automatic wr(input logic [6:0] addr, input logic [7:0] wd);
		logic [7:0] rd;
		xfer(1'b1, addr, wd, rd);
	endtask
	task automatic rd_chk(input string name, input logic [6:0] addr, input logic [7:0] exp,
		input logic [7:0] msk);
		logic [7:0] rd;
		xfer(1'b0, addr, 8'h00, rd);
		check(name, rd & msk, exp);
	endtask
	task automatic reset_values();
		check("port a oe", port_a_oe, 8'h00);
		check("port b oe", port_b_oe, 8'h00);
		check("txd pair", {6'h00, txd_a, txd_b}, 8'h03);
		check("irq drive", {7'h00, irq_oe}, 8'h00);
		check("port outs", port_a_out | port_b_out, 8'h00);
		check("ack drive", {7'h00, xfer_ack_oe}, 8'h00);
		rd_chk("int mask", `ADDR_INT_MASK, 8'h00, 8'hff);
		rd_chk("int pending", `ADDR_INT_PEND, 8'h00, 8'hff);
		rd_chk("out port", `ADDR_OUT_PORT, 8'h00, 8'hff);
		rd_chk("mode a", `ADDR_MODE_A, `RST_MODE, 8'hff);
		rd_chk("mode b", `ADDR_MODE_B, `RST_MODE, 8'hff);
	endtask
	task automatic grab_tx(output logic [7:0] b);
		int n;
		n = 0;
		while (txd_a !== 1'b0 && n < 2000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 2000)
		begin
			num_errors++;
			give_verdict();
		end
		repeat (BIT_CLKS / 2) @(posedge core_clk);
		check("tx start bit", {7'h00, txd_a}, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CLKS) @(posedge core_clk);
			b[i] = txd_a;
		end
		repeat (BIT_CLKS) @(posedge core_clk);
		check("tx stop bit", {7'h00, txd_a}, 8'h01);
	endtask
	task automatic send_rx(input logic [7:0] b);
		// start, eight data bits lsb first, stop
		for (int i = 0; i < 10; i++)
		begin
			rxd_a <= (i == 0) ? 1'b0 : ((i == 9) ? 1'b1 : b[i - 1]);
			repeat (BIT_CLKS) @(posedge core_clk);
		end
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		num_errors = 0;
		checks = 0;
		arst_n = 1'b0;
		reset_in = 1'b0;
		rxd_a = 1'b1;
		port_a_in = 8'h00;
		port_b_in = 8'h00;
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		reset_values();
		$display("test power-on values done");
		wr(`ADDR_INT_MASK, 8'h5a);
		wr(`ADDR_OUT_PORT, 8'hc3);
		check("port a out", port_a_out, 8'hc3);
		wr(`ADDR_OUT_PORT_B, 8'h69);
		check("port b out", port_b_out, 8'h69);
		wr(`ADDR_PORT_DIR_A, 8'hff);
		check("port a dir", port_a_oe, 8'hff);
		rd_chk("mask back", `ADDR_INT_MASK, 8'h5a, 8'hff);
		rd_chk("out port back", `ADDR_OUT_PORT, 8'hc3, 8'hff);
		rd_chk("unmapped", 7'h7f, 8'h00, 8'hff);
		port_a_in <= 8'ha5;
		port_b_in <= 8'h3c;
		repeat (8) @(posedge core_clk);
		rd_chk("pins a", `ADDR_PORT_IN_A, 8'ha5, 8'hff);
		rd_chk("pins b", `ADDR_PORT_IN_B, 8'h3c, 8'hff);
		$display("test register access done");
		wr(`ADDR_INT_MASK, 8'h00);
		wr(`ADDR_COS, 8'hff);
		wr(`ADDR_INT_PEND, 8'hff);
		rd_chk("cos cleared", `ADDR_INT_PEND, 8'h00, 8'h44);
		wr(`ADDR_CMD_A, 8'h04);
		rd_chk("tx a pending", `ADDR_INT_PEND, 8'h01, 8'h01);
		check("irq masked", {7'h00, irq_oe}, 8'h00);
		wr(`ADDR_INT_MASK, 8'h01);
		check("irq raised", {6'h00, irq_oe, irq_out_n}, 8'h02);
		wr(`ADDR_INT_MASK, 8'h00);
		check("irq dropped", {7'h00, irq_oe}, 8'h00);
		$display("test interrupt done");
		fork
			wr(`ADDR_DATA_A, 8'h4b);
			grab_tx(got);
		join
		check("tx byte", got, 8'h4b);
		wr(`ADDR_CMD_A, 8'h01);
		send_rx(8'h96);
		repeat (4 * BIT_CLKS) @(posedge core_clk);
		rd_chk("rx ready", `ADDR_STATE_A, 8'h01, 8'h01);
		wr(`ADDR_PORT_CFG, 8'h01);
		got = {7'h00, port_a_oe[0]};
		check("ready pin low drive", {7'h00, port_a_out[0]}, 8'h00);
		rd_chk("rx byte", `ADDR_DATA_A, 8'h96, 8'hff);
		check("ready pin follows", got ^ {7'h00, port_a_oe[0]}, 8'h01);
		wr(`ADDR_CMD_A, 8'h14);
		got = 8'h00;
		fork
			wr(`ADDR_DATA_A, 8'h00);
			repeat (20 * BIT_CLKS)
			begin
				@(posedge core_clk);
				got[0] = got[0] | (txd_a !== 1'b1);
			end
		join
		check("loop mark", got, 8'h00);
		$display("test serial done");
		wr(`ADDR_INT_MASK, 8'h5a);
		wr(`ADDR_OUT_PORT, 8'h77);
		wr(`ADDR_MODE_A, 8'h07);
		reset_in <= 1'b1;
		repeat (6) @(posedge core_clk);
		reset_in <= 1'b0;
		repeat (4) @(posedge core_clk);
		reset_values();
		$display("test reset pin done");
		give_verdict();
	end
endmodule // duart_x86_host_pin_interface_test
